// ---- rtl/multidrop_link_error_status.sv ----
/*
 * multi-drop link error status bank: one global error word, one word per station,
 * interrupt status and mask, and a control word with the auto-retry switch.
 * assumes link events arrive on sys_clk from the link engine, register bus on sys_clk.
 */
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "link_err_defines.svh"

module multidrop_link_error_status
    import link_err_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // register bus
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [`DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DATA_W-1:0] reg_rdata,
    // link engine events, same clock
    input wire logic [`ST_NUM-1:0] comm_err,
    input wire logic [`ST_NUM-1:0] rd_fail,
    input wire logic [`ST_NUM-1:0] wr_fail,
    input wire logic retry_busy,
    // link engine controls
    output logic [`ST_NUM-1:0] poll_en,
    output logic poll_pause,
    // interrupt
    output logic irq
);

    reg_req_t req;
    link_evt_t evt;
    init_state_t init_state_r;
    logic [`INIT_CNT_W-1:0] init_cnt_r;
    logic auto_retry_r;
    logic [`ST_NUM-1:0] st_en_r;
    logic [`ST_NUM-1:0] st_rd_log_r;
    logic [`ST_NUM-1:0] st_wr_log_r;
    logic g_rd_log_r;
    logic g_wr_log_r;
    logic [`IRQ_W-1:0] irq_stat_r;
    logic [`IRQ_W-1:0] irq_mask_r;
    logic g_cond;
    logic g_cond_q_r;
    logic init_go;
    logic init_busy;
    logic [`IRQ_W-1:0] irq_evt;
    logic [`IRQ_W-1:0] irq_stat_nxt;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign evt = '{comm_err: comm_err, rd_fail: rd_fail, wr_fail: wr_fail};

    // station decode: true when the address hits the station block
    function automatic logic is_station(input logic [`ADDR_W-1:0] a);
        is_station = (a >= `ST_BASE_OFF) && (a < (`ST_BASE_OFF + 8'(`ST_NUM)));
    endfunction

    function automatic logic [`ST_IDX_W-1:0] station_idx(input logic [`ADDR_W-1:0] a);
        logic [`ADDR_W-1:0] d;
        d = a - `ST_BASE_OFF;
        station_idx = d[`ST_IDX_W-1:0];
    endfunction

    // a zero in the init bit starts nothing
    assign init_go = req.wr && (req.addr == `GLOBAL_OFF) && req.wdata[`G_INIT_BIT];
    assign init_busy = (init_state_r == ST_CLEAR);

    // init sweep, reads one until finished
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_state_r <= ST_IDLE;
            init_cnt_r <= '0;
        end else begin
            case (init_state_r)
                ST_IDLE: begin
                    if (init_go) begin
                        init_state_r <= ST_CLEAR;
                        init_cnt_r <= `INIT_CYCLES;
                    end
                end
                ST_CLEAR: begin
                    if (init_cnt_r == `INIT_LAST) begin
                        init_state_r <= ST_IDLE;
                    end
                    init_cnt_r <= init_cnt_r - `INIT_LAST;
                end
                default: begin
                    init_state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // control word: auto retry switch, reset on
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_retry_r <= 1'b1;
        end else if (req.wr && req.addr == `CTRL_OFF) begin
            auto_retry_r <= req.wdata[`CTRL_RETRY_BIT];
        end
    end

    // station enable bits
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_en_r <= '1;
        end else if (auto_retry_r) begin
            // auto retry holds enables at one
            st_en_r <= '1;
        end else if (init_busy) begin
            st_en_r <= '1;
        end else begin
            for (int i = 0; i < `ST_NUM; i++) begin
                if (req.wr && is_station(req.addr) && station_idx(req.addr) == `ST_IDX_W'(i)) begin
                    st_en_r[i] <= req.wdata[`S_EN_BIT];
                end
                // error drops the enable, wins over a write
                if (evt.comm_err[i]) begin
                    st_en_r[i] <= 1'b0;
                end
            end
        end
    end

    // station sticky logs
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_rd_log_r <= '0;
            st_wr_log_r <= '0;
        end else if (init_busy) begin
            st_rd_log_r <= '0;
            st_wr_log_r <= '0;
        end else begin
            st_rd_log_r <= st_rd_log_r | evt.rd_fail;
            st_wr_log_r <= st_wr_log_r | evt.wr_fail;
        end
    end

    // global sticky logs
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            g_rd_log_r <= 1'b0;
            g_wr_log_r <= 1'b0;
        end else if (init_busy) begin
            g_rd_log_r <= 1'b0;
            g_wr_log_r <= 1'b0;
        end else begin
            // any failed read sets global log
            g_rd_log_r <= g_rd_log_r | (|evt.rd_fail);
            // any failed write sets global log
            g_wr_log_r <= g_wr_log_r | (|evt.wr_fail);
        end
    end

    // forced to zero without auto retry
    assign g_cond = auto_retry_r && (|(evt.comm_err & st_en_r));

    // polling controls
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            poll_en <= '0;
            poll_pause <= 1'b0;
        end else begin
            // enable bit gates polling; none during init
            poll_en <= init_busy ? '0 : st_en_r;
            poll_pause <= retry_busy;
        end
    end

    // interrupt events: rising condition, new read and write failures
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            g_cond_q_r <= 1'b0;
        end else begin
            g_cond_q_r <= g_cond;
        end
    end

    assign irq_evt = {|evt.wr_fail, |evt.rd_fail, g_cond & ~g_cond_q_r};

    // sticky status, write one to clear, set wins
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (req.wr && req.addr == `IRQ_STAT_OFF) begin
            irq_stat_nxt = irq_stat_nxt & ~req.wdata[`IRQ_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_evt;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (req.wr && req.addr == `IRQ_MASK_OFF) begin
                irq_mask_r <= req.wdata[`IRQ_W-1:0];
            end
        end
    end

    // level interrupt, registered
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // read data, one cycle after the strobe; zero otherwise
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `ZERO16;
        end else begin
            reg_rdata <= `ZERO16;
            if (req.rd) begin
                if (req.addr == `GLOBAL_OFF) begin
                    reg_rdata[`G_INIT_BIT] <= init_busy;
                    reg_rdata[`G_COND_BIT] <= g_cond;
                    reg_rdata[`G_RD_BIT] <= g_rd_log_r;
                    reg_rdata[`G_WR_BIT] <= g_wr_log_r;
                end else if (is_station(req.addr)) begin
                    reg_rdata[`S_EN_BIT] <= st_en_r[station_idx(req.addr)];
                    reg_rdata[`S_COND_BIT] <= evt.comm_err[station_idx(req.addr)];
                    reg_rdata[`S_RD_BIT] <= st_rd_log_r[station_idx(req.addr)];
                    reg_rdata[`S_WR_BIT] <= st_wr_log_r[station_idx(req.addr)];
                end else if (req.addr == `IRQ_STAT_OFF) begin
                    reg_rdata[`IRQ_W-1:0] <= irq_stat_r;
                end else if (req.addr == `IRQ_MASK_OFF) begin
                    reg_rdata[`IRQ_W-1:0] <= irq_mask_r;
                end else if (req.addr == `CTRL_OFF) begin
                    reg_rdata[`CTRL_RETRY_BIT] <= auto_retry_r;
                end
            end
        end
    end

    // init holds for the whole sweep then drops
    init_sweep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(init_busy) |-> init_busy [*8] ##1 !init_busy)
        else $error("init sweep length wrong");

    init_clears_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        init_busy |=> (st_rd_log_r == '0 && st_wr_log_r == '0 && !g_rd_log_r && !g_wr_log_r))
        else $error("init did not clear logs");

    zero_no_init_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!init_busy && req.wr && req.addr == `GLOBAL_OFF && !req.wdata[`G_INIT_BIT]) |=> !init_busy)
        else $error("zero write started init");

    cond_retry_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !auto_retry_r |-> !g_cond)
        else $error("condition set with retry off");

    cond_enabled_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (auto_retry_r && |(evt.comm_err & st_en_r)) |-> g_cond)
        else $error("condition missed enabled error");

    rd_log_sticks_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (|evt.rd_fail && !init_busy) |=> g_rd_log_r)
        else $error("global read log not set");

    wr_log_sticks_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (g_wr_log_r && !init_busy) |=> g_wr_log_r)
        else $error("global write log dropped");

    retry_holds_en_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        auto_retry_r |=> st_en_r == '1)
        else $error("enable not held with retry on");

    err_drops_en_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!auto_retry_r && !init_busy) |=> ((st_en_r & $past(evt.comm_err)) == '0))
        else $error("error did not drop enable");

    pause_follows_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        retry_busy |=> poll_pause)
        else $error("polling not paused");

    // sticky logs set on a failure and never drop outside the sweep
    st_rd_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !init_busy |=> (($past(evt.rd_fail) & ~st_rd_log_r) == '0))
        else $error("station read log not set");

    st_wr_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !init_busy |=> (($past(evt.wr_fail) & ~st_wr_log_r) == '0))
        else $error("station write log not set");

    st_rd_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !init_busy |=> (($past(st_rd_log_r) & ~st_rd_log_r) == '0))
        else $error("station read log dropped");

    st_wr_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !init_busy |=> (($past(st_wr_log_r) & ~st_wr_log_r) == '0))
        else $error("station write log dropped");

    rd_log_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (g_rd_log_r && !init_busy) |=> g_rd_log_r)
        else $error("global read log dropped");

    wr_log_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (|evt.wr_fail && !init_busy) |=> g_wr_log_r)
        else $error("global write log not set");

    poll_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !init_busy |=> (poll_en == $past(st_en_r)))
        else $error("poll gate differs from enables");

    poll_init_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        init_busy |=> (poll_en == '0))
        else $error("polling during init sweep");

    init_restart_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        init_busy |=> (st_en_r == '1))
        else $error("init did not restore enables");

    rd_cond_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (req.rd && req.addr == `GLOBAL_OFF && !auto_retry_r) |=> !reg_rdata[`G_COND_BIT])
        else $error("condition read with retry off");

    rd_cond_mask_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (req.rd && req.addr == `GLOBAL_OFF && (evt.comm_err & st_en_r) == '0) |=> !reg_rdata[`G_COND_BIT])
        else $error("condition read from disabled station");

    rd_init_busy_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (req.rd && req.addr == `GLOBAL_OFF && init_busy) |=> reg_rdata[`G_INIT_BIT])
        else $error("init bit read zero while sweeping");

    rd_reserved_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (req.rd && req.addr == `GLOBAL_OFF) |=> ((reg_rdata & ~`G_USED_MASK) == `ZERO16))
        else $error("reserved global bits read nonzero");

    rd_st_cond_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (req.rd && is_station(req.addr) && evt.comm_err == '0) |=> !reg_rdata[`S_COND_BIT])
        else $error("station condition read without error");

    rd_idle_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !req.rd |=> (reg_rdata == `ZERO16))
        else $error("read data not zero when idle");

    init_run_c: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(init_busy));
    drop_en_c: cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(&st_en_r));
    irq_c: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(irq));
    pause_c: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(poll_pause));

endmodule

`default_nettype wire

// ---- rtl/link_err_defines.svh ----
/*
 * constants for the multi-drop link error status bank: offsets, field positions, reset values, counts.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef LINK_ERR_DEFINES_SVH
`define LINK_ERR_DEFINES_SVH

// station count and address layout
`define ST_NUM 8
`define ST_IDX_W 3
`define ADDR_W 8
`define DATA_W 16
`define GLOBAL_OFF 8'h00
`define ST_BASE_OFF 8'h10
`define IRQ_STAT_OFF 8'h04
`define IRQ_MASK_OFF 8'h05
`define CTRL_OFF 8'h06
// global word fields
`define G_INIT_BIT 1
`define G_COND_BIT 4
`define G_RD_BIT 6
`define G_WR_BIT 7
// station word fields
`define S_EN_BIT 0
`define S_COND_BIT 4
`define S_RD_BIT 6
`define S_WR_BIT 7
// interrupt status fields
`define I_COND_BIT 0
`define I_RD_BIT 1
`define I_WR_BIT 2
`define IRQ_W 3
// clear sweep length: one cycle per station
`define INIT_CYCLES 4'h8
`define INIT_CNT_W 4
`define ZERO16 16'h0000
// last count of the clear sweep
`define INIT_LAST 4'h1
// control word: auto retry switch
`define CTRL_RETRY_BIT 0
// global word bits that carry a field; the rest read zero
`define G_USED_MASK 16'h00D2

`endif

// ---- rtl/link_err_pkg.sv ----
/*
 * types for the multi-drop link error status bank.
 * assumes link_err_defines.svh sits on the include path.
 */
`include "link_err_defines.svh"

package link_err_pkg;

    // register bus request from software
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } reg_req_t;

    // link engine events for one cycle
    typedef struct packed {
        logic [`ST_NUM-1:0] comm_err;
        logic [`ST_NUM-1:0] rd_fail;
        logic [`ST_NUM-1:0] wr_fail;
    } link_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CLEAR
    } init_state_t;

endpackage

// ---- dv/link_station_model.sv ----
/*
 * behavioural link engine with its numbered stations, facing the error status bank.
 * assumes the bench commands faults on sys_clk; events are launched one edge later.
 */
`timescale 1ns/1ps
`default_nettype none
`include "link_err_defines.svh"

module link_station_model
    import link_err_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // polling gate from the bank
    input wire logic [`ST_NUM-1:0] poll_en,
    // fault commands from the bench
    input wire logic [`ST_NUM-1:0] cmd_err,
    input wire logic [`ST_NUM-1:0] cmd_rd,
    input wire logic [`ST_NUM-1:0] cmd_wr,
    input wire logic cmd_busy,
    // link events to the bank
    output var link_evt_t evt,
    output logic retry_busy
);

    // communication errors follow the bench command each cycle; transfer faults only on stations being polled
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt <= '0;
            retry_busy <= 1'b0;
        end else begin
            evt.comm_err <= cmd_err;
            evt.rd_fail <= cmd_rd & poll_en;
            evt.wr_fail <= cmd_wr & poll_en;
            retry_busy <= cmd_busy;
        end
    end

endmodule

`default_nettype wire

// ---- dv/test_multidrop_link_error_status.sv ----
/*
 * self-checking bench for the link error status bank: register reads and writes, fault events, init sweep.
 * assumes the station model sits on the link side and the bench owns the register port.
 */
`timescale 1ns/1ps
`default_nettype none
`include "link_err_defines.svh"

module test_multidrop_link_error_status;
    import link_err_pkg::*;

    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [`ADDR_W-1:0] reg_addr = 8'h00;
    logic [`DATA_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [`DATA_W-1:0] reg_rdata;
    logic [`ST_NUM-1:0] cmd_err = 8'h00;
    logic [`ST_NUM-1:0] cmd_rd = 8'h00;
    logic [`ST_NUM-1:0] cmd_wr = 8'h00;
    logic cmd_busy = 1'b0;
    link_evt_t evt;
    logic retry_busy;
    logic [`ST_NUM-1:0] poll_en;
    logic poll_pause;
    logic irq;
    int n_mismatch = 0;
    int cmp_count = 0;

    multidrop_link_error_status uut (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comm_err(evt.comm_err),
        .rd_fail(evt.rd_fail), .wr_fail(evt.wr_fail), .retry_busy(retry_busy),
        .poll_en(poll_en), .poll_pause(poll_pause), .irq(irq)
    );

    link_station_model stations (
        .sys_clk(sys_clk), .arst_n(arst_n), .poll_en(poll_en), .cmd_err(cmd_err),
        .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_busy(cmd_busy), .evt(evt), .retry_busy(retry_busy)
    );

    // 25 MHz clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
        chk_word({8'h00, got}, {8'h00, exp});
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask

    // one-cycle write strobe
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        bus_rd(a, d);
        chk_word(d, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // transfer faults as one-cycle pulses from the stations
    task automatic fault(input logic [7:0] r, input logic [7:0] w);
        @(posedge sys_clk);
        cmd_rd <= r;
        cmd_wr <= w;
        @(posedge sys_clk);
        cmd_rd <= 8'h00;
        cmd_wr <= 8'h00;
        idle(3);
    endtask

    // start init and poll the busy bit under a bound
    task automatic do_init();
        logic [15:0] d;
        bus_wr(`GLOBAL_OFF, 16'h0002);
        bus_rd(`GLOBAL_OFF, d);
        chk_bit(d[`G_INIT_BIT], 1'b1);
        for (int k = 0; k < 20; k++) begin
            bus_rd(`GLOBAL_OFF, d);
            if (d[`G_INIT_BIT] === 1'b0) begin
                return;
            end
        end
        n_mismatch++;
        wrap_up();
    endtask

    initial begin
        idle(8);
        arst_n <= 1'b1;
        idle(2);
        // power-up state
        chk_vec(poll_en, 8'hFF);
        for (int i = 0; i < `ST_NUM; i++) begin
            rd_chk(`ST_BASE_OFF + 8'(i), 16'h0001);
        end
        rd_chk(`GLOBAL_OFF, 16'h0000);
        // transfer faults latch in both words
        fault(8'h04, 8'h20);
        rd_chk(`GLOBAL_OFF, 16'h00C0);
        rd_chk(8'h12, 16'h0041);
        rd_chk(8'h15, 16'h0081);
        rd_chk(8'h10, 16'h0001);
        // interrupt raise, mask, clear
        rd_chk(`IRQ_STAT_OFF, 16'h0006);
        chk_bit(irq, 1'b0);
        bus_wr(`IRQ_MASK_OFF, 16'h0006);
        idle(2);
        chk_bit(irq, 1'b1);
        rd_chk(`IRQ_MASK_OFF, 16'h0006);
        bus_wr(`IRQ_STAT_OFF, 16'h0006);
        idle(2);
        chk_bit(irq, 1'b0);
        rd_chk(`IRQ_STAT_OFF, 16'h0000);
        // live error with auto retry on
        cmd_err <= 8'h08;
        idle(3);
        rd_chk(`GLOBAL_OFF, 16'h00D0);
        rd_chk(8'h13, 16'h0011);
        chk_vec(poll_en, 8'hFF);
        cmd_err <= 8'h00;
        idle(3);
        rd_chk(`GLOBAL_OFF, 16'h00C0);
        rd_chk(8'h13, 16'h0001);
        rd_chk(`IRQ_STAT_OFF, 16'h0001);
        // zero and reserved writes leave the logs alone
        bus_wr(`GLOBAL_OFF, 16'h0000);
        bus_wr(`GLOBAL_OFF, 16'hFFFD);
        rd_chk(`GLOBAL_OFF, 16'h00C0);
        // init clears every log
        do_init();
        rd_chk(`GLOBAL_OFF, 16'h0000);
        rd_chk(8'h12, 16'h0001);
        rd_chk(8'h15, 16'h0001);
        // auto retry off: failed station dropped
        rd_chk(`CTRL_OFF, 16'h0001);
        bus_wr(`CTRL_OFF, 16'h0000);
        cmd_err <= 8'h02;
        idle(3);
        rd_chk(`GLOBAL_OFF, 16'h0000);
        rd_chk(8'h11, 16'h0010);
        chk_vec(poll_en, 8'hFD);
        bus_wr(8'h16, 16'h0000);
        idle(2);
        chk_vec(poll_en, 8'hBD);
        rd_chk(8'h16, 16'h0000);
        cmd_err <= 8'h00;
        do_init();
        idle(2);
        chk_vec(poll_en, 8'hFF);
        rd_chk(8'h11, 16'h0001);
        // unmapped place
        bus_wr(8'h30, 16'hFFFF);
        rd_chk(8'h30, 16'h0000);
        // retry pauses polling
        cmd_busy <= 1'b1;
        idle(3);
        chk_bit(poll_pause, 1'b1);
        cmd_busy <= 1'b0;
        idle(3);
        chk_bit(poll_pause, 1'b0);
        wrap_up();
    end

endmodule

`default_nettype wire
